/* File: common/emc_pkg.sv */
// Constants for the external memory configuration register bank.
// Assumes one core clock and a simple byte-addressed register port.
package emc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SDRAM_CONFIG = 8'h08;
  localparam logic [7:0] OFS_REFRESH_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_REGION_BASE = 8'h10;
  localparam logic [7:0] OFS_REGION_LAST = 8'h1c;
  localparam int NUM_REGIONS = 4;

  // sdram_config field positions
  localparam int SR_BIT = 31;
  localparam int PD_BIT = 30;
  localparam int PD_REFR_BIT = 29;
  localparam int NARROW_BIT = 14;
  localparam int CL_LSB = 9;
  localparam int UNLOCK_BIT = 8;
  localparam int BANK_LSB = 4;
  localparam int PAGE_LSB = 0;
  localparam logic [31:0] SDCFG_RSVD_MASK = 32'h1fffb188;

  // async_region_config field positions
  localparam int SS_BIT = 31;
  localparam int EXT_WAIT_BIT = 30;
  localparam int WSETUP_LSB = 26;
  localparam int WSTROBE_LSB = 20;
  localparam int WHOLD_LSB = 17;
  localparam int RSETUP_LSB = 13;
  localparam int RSTROBE_LSB = 7;
  localparam int RHOLD_LSB = 4;
  localparam int TURN_LSB = 2;
  localparam int WIDTH_LSB = 0;

  // Values after reset
  localparam logic SR_RST = 1'b0;
  localparam logic PD_RST = 1'b0;
  localparam logic PD_REFR_RST = 1'b0;
  localparam logic NARROW_RST = 1'b0;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] BANK_RST = 3'h2;
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic [12:0] REFRESH_RST = 13'h0100;
  localparam logic [31:0] REGION_RST = 32'h3ffffffc;

  // Refresh values below this are replaced by twice the cycle time plus one
  localparam logic [12:0] REFRESH_MIN = 13'h0020;
  localparam logic [3:0] FULL_WORD = 4'hf;

  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_SELF_REF,
    PWR_DOWN,
    PWR_PD_REFRESH
  } emc_pwr_t;
endpackage

/* File: rtl/emc_region_cfg.sv */
// One asynchronous region configuration word.
// Assumes word writes; narrower writes are ignored.
`timescale 1ns/1ns
module emc_region_cfg
  import emc_pkg::*;
#(
  parameter logic [7:0] OFFSET = 8'h10
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  output logic [31:0] region_cfg
);
  typedef struct packed {
    logic [31:0] cfg;
  } emc_region_st_t;

  emc_region_st_t st_q;
  emc_region_st_t st_d;
  logic hit;

  assign hit = reg_wr && (reg_addr == OFFSET) && (reg_be == FULL_WORD);

  always_comb begin
    st_d = st_q;
    if (hit) begin
      st_d.cfg = reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q.cfg <= REGION_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign region_cfg = st_q.cfg;

  AST_REGION_NEW_CFG: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    hit |=> (region_cfg == $past(reg_wdata)))
    else $error("Region config not taken from write");
endmodule

/* File: rtl/emc_power_ctl.sv */
// SDRAM low-power mode tracker: self-refresh, power-down, refresh in power-down.
// Assumes refresh_needed is a level from the refresh counter on core_clk.
`timescale 1ns/1ns
module emc_power_ctl
  import emc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sr_req,
  input wire logic pd_req,
  input wire logic pd_refr_en,
  input wire logic refresh_needed,
  output logic self_refresh_active,
  output logic power_down_active,
  output logic auto_refresh_cmd
);
  typedef struct packed {
    emc_pwr_t state;
    logic sr_act;
    logic pd_act;
    logic refr;
  } emc_pwr_st_t;

  emc_pwr_st_t st_q;
  emc_pwr_st_t st_d;

  always_comb begin
    st_d = st_q;
    case (st_q.state)
      PWR_DOWN: begin
        if (sr_req) begin
          st_d.state = PWR_SELF_REF;
        end else if (!pd_req) begin
          st_d.state = PWR_NORMAL;
        end else if (pd_refr_en && refresh_needed) begin
          st_d.state = PWR_PD_REFRESH;
        end
      end
      default: begin
        if (sr_req) begin
          st_d.state = PWR_SELF_REF;
        end else if (pd_req) begin
          st_d.state = PWR_DOWN;
        end else begin
          st_d.state = PWR_NORMAL;
        end
      end
    endcase
    st_d.sr_act = (st_d.state == PWR_SELF_REF);
    st_d.pd_act = (st_d.state == PWR_DOWN);
    st_d.refr = (st_d.state == PWR_PD_REFRESH);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= '{state: PWR_NORMAL, sr_act: 1'b0, pd_act: 1'b0, refr: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign self_refresh_active = st_q.sr_act;
  assign power_down_active = st_q.pd_act;
  assign auto_refresh_cmd = st_q.refr;

  AST_PD_REFRESH_ONE_CYCLE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    auto_refresh_cmd |=> !auto_refresh_cmd)
    else $error("Auto-refresh in power-down longer than one cycle");
endmodule

/* File: rtl/emc_config_regs.sv */
// External memory interface configuration register bank.
// Assumes a same-clock register port with byte enables; timing register lives outside.
//
// Behaviour
// - Self-refresh bit enters and leaves self-refresh
// - Power-down bit enters and leaves power-down
// - Both set: self-refresh wins
// - Refresh-in-power-down leaves power-down for auto-refresh
// - Narrow bus bit; write starts initialization
// - CAS latency codes two and three
// - CAS updates only with unlock; unlock reads zero
// - Bank count field; write starts initialization
// - Column bits field; write starts initialization
// - Reserved bits read zero
// - Refresh period in memory clock cycles
// - Small refresh value loads twice cycle time plus one
// - Region config applies to following transfers
// - Select-strobe mode bit per region
// - Extended wait enable bit per region
// - Write phases encoded as count minus one
// - Read phases encoded as count minus one
// - Turnaround field is cycles minus one
// - Async bus width field
// - Lower three byte write starts initialization
`timescale 1ns/1ns
module emc_config_regs
  import emc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic [4:0] refresh_cycle_time,
  input wire logic refresh_needed,
  output logic sdram_init_start,
  output logic self_refresh_active,
  output logic power_down_active,
  output logic auto_refresh_cmd,
  output logic refresh_in_power_down,
  output logic narrow_bus_sel,
  output logic [2:0] cas_latency,
  output logic [2:0] bank_count_sel,
  output logic [2:0] column_bits_sel,
  output logic [12:0] refresh_period,
  output logic [31:0] region0_cfg,
  output logic [31:0] region1_cfg,
  output logic [31:0] region2_cfg,
  output logic [31:0] region3_cfg
);
  typedef struct packed {
    logic sr;
    logic pd;
    logic pd_refr;
    logic narrow;
    logic [2:0] cl;
    logic [2:0] bank;
    logic [2:0] page;
    logic [12:0] refresh;
    logic [31:0] rdata;
    logic rvalid;
    logic init;
  } emc_cfg_st_t;

  emc_cfg_st_t st_q;
  emc_cfg_st_t st_d;
  logic sdcfg_wr;
  logic refr_wr;
  logic [31:0] sdcfg_word;
  logic [12:0] refresh_floor;
  logic [31:0] region_w [NUM_REGIONS];
  logic [7:0] region_rel;
  logic [1:0] region_idx;

  assign sdcfg_wr = reg_wr && (reg_addr == OFS_SDRAM_CONFIG);
  assign refr_wr = reg_wr && (reg_addr == OFS_REFRESH_CONTROL) && (reg_be == FULL_WORD);
  assign refresh_floor = {7'h00, refresh_cycle_time, 1'b1};
  assign region_rel = reg_addr - OFS_REGION_BASE;
  assign region_idx = region_rel[3:2];

  // Read-back word; unlock and reserved bits always zero
  assign sdcfg_word = {st_q.sr, st_q.pd, st_q.pd_refr, 14'h0000, st_q.narrow, 2'b00,
                       st_q.cl, 1'b0, 1'b0, st_q.bank, 1'b0, st_q.page};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGIONS; gi++) begin : g_region
      emc_region_cfg #(
        .OFFSET(8'(OFS_REGION_BASE + 8'(4 * gi)))
      ) u_region (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_be(reg_be),
        .reg_wr(reg_wr),
        .region_cfg(region_w[gi])
      );
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    st_d.init = 1'b0;
    st_d.rvalid = 1'b0;
    // Top byte: low-power mode bits, no initialization
    if (sdcfg_wr && reg_be[3]) begin
      st_d.sr = reg_wdata[SR_BIT];
      st_d.pd = reg_wdata[PD_BIT];
      st_d.pd_refr = reg_wdata[PD_REFR_BIT];
    end
    if (sdcfg_wr && reg_be[1]) begin
      st_d.narrow = reg_wdata[NARROW_BIT];
      if (reg_wdata[UNLOCK_BIT]) begin
        st_d.cl = reg_wdata[CL_LSB +: 3];
      end
    end
    if (sdcfg_wr && reg_be[0]) begin
      st_d.bank = reg_wdata[BANK_LSB +: 3];
      st_d.page = reg_wdata[PAGE_LSB +: 3];
    end
    if (sdcfg_wr && (reg_be[2:0] != 3'b000)) begin
      st_d.init = 1'b1;
    end
    if (refr_wr) begin
      if (reg_wdata[12:0] < REFRESH_MIN) begin
        st_d.refresh = refresh_floor;
      end else begin
        st_d.refresh = reg_wdata[12:0];
      end
    end
    if (reg_rd) begin
      st_d.rvalid = 1'b1;
      if (reg_addr == OFS_SDRAM_CONFIG) begin
        st_d.rdata = sdcfg_word;
      end else if (reg_addr == OFS_REFRESH_CONTROL) begin
        st_d.rdata = {19'h00000, st_q.refresh};
      end else if ((reg_addr >= OFS_REGION_BASE) && (reg_addr <= OFS_REGION_LAST)
                   && (reg_addr[1:0] == 2'b00)) begin
        st_d.rdata = region_w[region_idx];
      end else begin
        st_d.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q.sr <= SR_RST;
      st_q.pd <= PD_RST;
      st_q.pd_refr <= PD_REFR_RST;
      st_q.narrow <= NARROW_RST;
      st_q.cl <= CL_RST;
      st_q.bank <= BANK_RST;
      st_q.page <= PAGE_RST;
      st_q.refresh <= REFRESH_RST;
      st_q.rdata <= 32'h00000000;
      st_q.rvalid <= 1'b0;
      st_q.init <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  emc_power_ctl u_power (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sr_req(st_q.sr),
    .pd_req(st_q.pd),
    .pd_refr_en(st_q.pd_refr),
    .refresh_needed(refresh_needed),
    .self_refresh_active(self_refresh_active),
    .power_down_active(power_down_active),
    .auto_refresh_cmd(auto_refresh_cmd)
  );

  assign reg_rdata = st_q.rdata;
  assign reg_rdata_valid = st_q.rvalid;
  assign sdram_init_start = st_q.init;
  assign refresh_in_power_down = st_q.pd_refr;
  assign narrow_bus_sel = st_q.narrow;
  assign cas_latency = st_q.cl;
  assign bank_count_sel = st_q.bank;
  assign column_bits_sel = st_q.page;
  assign refresh_period = st_q.refresh;
  assign region0_cfg = region_w[0];
  assign region1_cfg = region_w[1];
  assign region2_cfg = region_w[2];
  assign region3_cfg = region_w[3];

  AST_SR_ENTER: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdcfg_wr && reg_be[3] && reg_wdata[SR_BIT]) |-> ##2 self_refresh_active)
    else $error("Self-refresh not entered two cycles after request");

  AST_SR_EXIT: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !st_q.sr |=> !self_refresh_active)
    else $error("Self-refresh held after request cleared");

  AST_PD_ENTER: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (st_q.pd && !st_q.sr && !st_q.pd_refr) |=> power_down_active)
    else $error("Power-down not entered");

  AST_PD_EXIT: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !st_q.pd |=> (!power_down_active && !auto_refresh_cmd))
    else $error("Power-down held after request cleared");

  AST_SR_PRIORITY: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (st_q.sr && st_q.pd) |=> (self_refresh_active && !power_down_active))
    else $error("Power-down chosen over self-refresh");

  AST_PD_REFRESH: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (power_down_active && st_q.pd && !st_q.sr && st_q.pd_refr && refresh_needed)
    |=> (auto_refresh_cmd && !power_down_active))
    else $error("No auto-refresh from power-down");

  AST_INIT_LOW_BYTES: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdcfg_wr && (reg_be[2:0] != 3'b000)) |=> sdram_init_start)
    else $error("Initialization start missing after lower-byte write");

  AST_INIT_TOP_BYTE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdram_init_start) |-> $past(sdcfg_wr && (reg_be[2:0] != 3'b000)))
    else $error("Initialization started without a lower-byte write");

  AST_CAS_LOCKED: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdcfg_wr && !reg_wdata[UNLOCK_BIT]) |=> $stable(cas_latency))
    else $error("CAS latency changed on a locked write");

  AST_CAS_UNLOCKED: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdcfg_wr && reg_be[1] && reg_wdata[UNLOCK_BIT])
    |=> (cas_latency == $past(reg_wdata[CL_LSB +: 3])))
    else $error("CAS latency not taken on unlocked write");

  AST_SDCFG_RSVD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd && (reg_addr == OFS_SDRAM_CONFIG)) |=> ((reg_rdata & SDCFG_RSVD_MASK) == 32'h0)
    )
    else $error("Reserved or unlock bit read as one");

  AST_REFRESH_FLOOR: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (refr_wr && (reg_wdata[12:0] < REFRESH_MIN))
    |=> (refresh_period == {7'h00, $past(refresh_cycle_time), 1'b1}))
    else $error("Small refresh value not replaced");

  AST_REFRESH_LOAD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (refr_wr && (reg_wdata[12:0] >= REFRESH_MIN)) |=> (refresh_period == $past(reg_wdata[12:0])))
    else $error("Refresh period not loaded");

  AST_READ_ONE_CYCLE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reg_rd |=> reg_rdata_valid)
    else $error("Read answer missing");

  AST_NARROW_WRITE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdcfg_wr && reg_be[1]) |=> (narrow_bus_sel == $past(reg_wdata[NARROW_BIT])))
    else $error("Narrow bus bit not taken from write");

  AST_BANK_PAGE_WRITE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdcfg_wr && reg_be[0]) |=> ((bank_count_sel == $past(reg_wdata[BANK_LSB +: 3]))
    && (column_bits_sel == $past(reg_wdata[PAGE_LSB +: 3]))))
    else $error("Bank or page field not taken from write");

  AST_PD_REFR_WRITE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (sdcfg_wr && reg_be[3]) |=> (refresh_in_power_down == $past(reg_wdata[PD_REFR_BIT])))
    else $error("Refresh in power-down bit not taken from write");

  AST_REFRESH_RSVD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd && (reg_addr == OFS_REFRESH_CONTROL)) |=> (reg_rdata[31:13] == 19'h00000))
    else $error("Reserved refresh bits read as one");

  AST_MODE_EXCLUSIVE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(self_refresh_active && power_down_active))
    else $error("Self-refresh and power-down both active");

  AST_REFRESH_HELD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !refr_wr |=> $stable(refresh_period))
    else $error("Refresh period changed without a word write");

  AST_REGION0_READ: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd && (reg_addr == OFS_REGION_BASE)) |=> (reg_rdata == $past(region0_cfg)))
    else $error("First region word read back wrong");

  AST_REGION3_READ: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_rd && (reg_addr == OFS_REGION_LAST)) |=> (reg_rdata == $past(region3_cfg)))
    else $error("Last region word read back wrong");
endmodule

/* File: tb/emc_sdram_model.sv */
// Far-side model: timing register field and refresh counter.
// Assumes the bank's refresh period and auto-refresh pulse on core_clk.
`timescale 1ns/1ns
module emc_sdram_model #(
  parameter logic [4:0] REFR_CYCLE = 5'h05
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [12:0] refresh_period,
  input wire logic auto_refresh_cmd,
  output logic [4:0] refresh_cycle_time,
  output logic refresh_needed
);
  logic [12:0] cnt_q;

  assign refresh_cycle_time = REFR_CYCLE;

  // Level raised each period, dropped once a refresh is issued
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_q <= 13'h0000;
      refresh_needed <= 1'b0;
    end else begin
      if (auto_refresh_cmd) begin
        refresh_needed <= 1'b0;
      end else if (cnt_q >= refresh_period) begin
        refresh_needed <= 1'b1;
      end
      cnt_q <= (cnt_q >= refresh_period) ? 13'h0000 : cnt_q + 13'h0001;
    end
  end
endmodule

/* File: tb/tb.sv */
// Testbench for the external memory configuration register bank.
// Assumes the same-clock register port and the far-side model beside it.
`timescale 1ns/1ns
module tb;
  import emc_pkg::*;
  localparam logic [4:0] REFR_CYCLE = 5'h05;
  localparam logic [31:0] PATS [4] = '{32'h80000001, 32'h40000000, 32'h04228a94, 32'h3c00000c};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [3:0] reg_be = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_rdata_valid, sdram_init_start, self_refresh_active, power_down_active;
  logic auto_refresh_cmd, refresh_in_power_down, narrow_bus_sel, refresh_needed;
  logic [2:0] cas_latency, bank_count_sel, column_bits_sel;
  logic [12:0] refresh_period;
  logic [4:0] refresh_cycle_time;
  logic [31:0] region_cfg [4];
  logic [31:0] wd;
  int error_cnt = 0;
  int n_checks = 0;
  int n;

  always #4 core_clk = ~core_clk;

  emc_config_regs DUT (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_be, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rdata_valid, .refresh_cycle_time, .refresh_needed,
    .sdram_init_start, .self_refresh_active, .power_down_active, .auto_refresh_cmd,
    .refresh_in_power_down, .narrow_bus_sel, .cas_latency, .bank_count_sel,
    .column_bits_sel, .refresh_period, .region0_cfg(region_cfg[0]),
    .region1_cfg(region_cfg[1]), .region2_cfg(region_cfg[2]), .region3_cfg(region_cfg[3])
  );

  emc_sdram_model #(.REFR_CYCLE(REFR_CYCLE)) mem (
    .core_clk, .reset_n, .refresh_period, .auto_refresh_cmd,
    .refresh_cycle_time, .refresh_needed
  );

  task automatic print_verdict();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_be <= be;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata_valid", 32'(reg_rdata_valid), 32'h1);
    chk("rdata", reg_rdata, exp);
  endtask

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(OFS_SDRAM_CONFIG, 32'h00000620);
    rd(OFS_REFRESH_CONTROL, 32'h00000100);
    for (int i = 0; i < NUM_REGIONS; i++) begin
      rd(OFS_REGION_BASE + 8'(4 * i), REGION_RST);
    end
    rd(8'h00, 32'h0);
    rd(8'h20, 32'h0);
    // Mode bits by top-byte writes: none, pd, sr, both, none
    for (int i = 0; i < 5; i++) begin
      wd = {2'(i % 4), 30'h0};
      wr(OFS_SDRAM_CONFIG, wd, 4'h8);
      chk("init_top", 32'(sdram_init_start), 32'h0);
      step();
      chk("self_refresh", 32'(self_refresh_active), 32'(wd[31]));
      chk("power_down", 32'(power_down_active), 32'(wd[31:30] == 2'b01));
    end
    // CAS field locked, then unlocked
    wr(OFS_SDRAM_CONFIG, 32'h00004400, 4'h2);
    chk("init_narrow", 32'(sdram_init_start), 32'h1);
    chk("narrow", 32'(narrow_bus_sel), 32'h1);
    chk("cl_locked", 32'(cas_latency), 32'h3);
    wr(OFS_SDRAM_CONFIG, 32'h00004500, 4'h2);
    chk("cl", 32'(cas_latency), 32'h2);
    rd(OFS_SDRAM_CONFIG, 32'h00004420);
    wr(OFS_SDRAM_CONFIG, 32'h0, 4'h4);
    chk("init_byte2", 32'(sdram_init_start), 32'h1);
    step();
    chk("init_pulse", 32'(sdram_init_start), 32'h0);
    wr(OFS_SDRAM_CONFIG, 32'h00004712, FULL_WORD);
    rd(OFS_SDRAM_CONFIG, 32'h00004612);
    for (int i = 0; i < 4; i++) begin
      wd = {25'h0, 3'(i % 3), 1'b0, 3'(i)};
      wr(OFS_SDRAM_CONFIG, wd, 4'h1);
      chk("init_low", 32'(sdram_init_start), 32'h1);
      chk("bank", 32'(bank_count_sel), 32'(i % 3));
      chk("page", 32'(column_bits_sel), 32'(i));
      rd(OFS_SDRAM_CONFIG, 32'h00004600 | wd);
    end
    // Refresh period and its floor
    wr(OFS_REFRESH_CONTROL, 32'h00001fff, FULL_WORD);
    chk("rr_max", 32'(refresh_period), 32'h1fff);
    wr(OFS_REFRESH_CONTROL, 32'h0000001f, FULL_WORD);
    chk("rr_floor", 32'(refresh_period), 32'(2 * REFR_CYCLE + 1));
    wr(OFS_REFRESH_CONTROL, 32'h00000020, FULL_WORD);
    chk("rr_edge", 32'(refresh_period), 32'h20);
    wr(OFS_REFRESH_CONTROL, 32'h0, 4'h1);
    rd(OFS_REFRESH_CONTROL, 32'h20);
    // Refresh from power-down
    wr(OFS_SDRAM_CONFIG, 32'h60000000, 4'h8);
    chk("pd_refresh_bit", 32'(refresh_in_power_down), 32'h1);
    n = 0;
    while (auto_refresh_cmd !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    chk("auto_refresh", 32'(auto_refresh_cmd), 32'h1);
    chk("pd_left", 32'(power_down_active), 32'h0);
    step();
    chk("pd_back", 32'(power_down_active), 32'h1);
    wr(OFS_SDRAM_CONFIG, 32'h0, 4'h8);
    step();
    chk("pd_exit", 32'(power_down_active), 32'h0);
    // Region words
    for (int i = 0; i < NUM_REGIONS; i++) begin
      wr(OFS_REGION_BASE + 8'(4 * i), PATS[i], FULL_WORD);
      chk("region_out", region_cfg[i], PATS[i]);
      rd(OFS_REGION_BASE + 8'(4 * i), PATS[i]);
    end
    wr(OFS_REGION_BASE, 32'h0, 4'h1);
    chk("region_byte", region_cfg[0], PATS[0]);
    print_verdict();
  end
endmodule
